/* design/peis_hdr_buffer.sv */
// Small FIFO holding completion headers waiting to be answered.
// Assumes the writer honours full; pushes while full are dropped.
module peis_hdr_buffer
  import peis_pkg::*;
(
  input wire logic clk, // User clock
  input wire logic nrst, // Async reset, active low
  input wire logic push, // Write one entry
  input wire logic [ENTRY_W-1:0] pushData, // Entry to store
  input wire logic pop, // Drop head entry
  output logic [ENTRY_W-1:0] headData, // Oldest entry
  output logic empty, // No entry held
  output logic full, // No room left
  output logic fullNxt, // Full after this edge
  output logic [CNT_W-1:0] count // Entries held
);
  logic [ENTRY_W-1:0] mem_r [BUF_DEPTH];
  logic [ENTRY_W-1:0] mem_nxt [BUF_DEPTH];
  logic [PTR_W-1:0] wPtr_r;
  logic [PTR_W-1:0] wPtr_nxt;
  logic [PTR_W-1:0] rPtr_r;
  logic [PTR_W-1:0] rPtr_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic doPush;
  logic doPop;

  // ************************************************************
  // Pointer and storage update
  // ************************************************************
  always_comb begin
    doPush = push && (cnt_r != CNT_W'(BUF_DEPTH));
    doPop = pop && (cnt_r != '0);
    mem_nxt = mem_r;
    wPtr_nxt = wPtr_r;
    rPtr_nxt = rPtr_r;
    cnt_nxt = cnt_r;
    if (doPush) begin
      mem_nxt[wPtr_r] = pushData;
      wPtr_nxt = wPtr_r + PTR_W'(1);
    end
    if (doPop) begin
      rPtr_nxt = rPtr_r + PTR_W'(1);
    end
    if (doPush && !doPop) begin
      cnt_nxt = cnt_r + CNT_W'(1);
    end else if (doPop && !doPush) begin
      cnt_nxt = cnt_r - CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < BUF_DEPTH; i++) begin
        mem_r[i] <= '0;
      end
      wPtr_r <= '0;
      rPtr_r <= '0;
      cnt_r <= '0;
    end else begin
      mem_r <= mem_nxt;
      wPtr_r <= wPtr_nxt;
      rPtr_r <= rPtr_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign headData = mem_r[rPtr_r];
  assign empty = (cnt_r == '0);
  assign full = (cnt_r == CNT_W'(BUF_DEPTH));
  assign fullNxt = (cnt_nxt == CNT_W'(BUF_DEPTH));
  assign count = cnt_r;
endmodule

/* design/peis_pkg.sv */
// Shared constants and types for the error and interrupt sideband.
// Assumes one user clock; second-domain strobes are synchronised inside.
package peis_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int HDR_W = 48;
  localparam int ENTRY_W = 49;
  localparam int LOCK_BIT = 48;
  localparam int BUF_DEPTH = 4;
  localparam int PTR_W = 2;
  localparam int CNT_W = 3;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int SLOW_W = 4;
  localparam int CNT16_W = 16;

  // ************************************************************
  // Register map (index on regAddr)
  // ************************************************************
  localparam logic [ADDR_W-1:0] REG_CFG = 4'h0;
  localparam logic [ADDR_W-1:0] REG_ERR = 4'h1;
  localparam logic [ADDR_W-1:0] REG_HDR_LO = 4'h2;
  localparam logic [ADDR_W-1:0] REG_HDR_HI = 4'h3;
  localparam logic [ADDR_W-1:0] REG_POP = 4'h4;
  localparam logic [ADDR_W-1:0] REG_INT = 4'h5;

  // Configuration fields
  localparam int CFG_POIS_BIT = 0;
  localparam int CFG_MSI_BIT = 1;
  localparam int CFG_MME_LSB = 2;
  localparam int CFG_MME_MSB = 4;
  localparam int CFG_DATA_LSB = 8;
  localparam int CFG_DATA_MSB = 15;
  localparam logic [2:0] MME_MAX = 3'h5;
  localparam logic [2:0] MME_RST = 3'h0;
  localparam logic [7:0] MSG_DATA_RST = 8'h00;

  // Error status bits, write one to clear
  localparam int ERR_UR = 0;
  localparam int ERR_CA = 1;
  localparam int ERR_CTO = 2;
  localparam int ERR_MALF = 3;
  localparam int ERR_MCB = 4;
  localparam int ERR_POIS = 5;
  localparam int ERR_CTO_UNREC = 6;
  localparam int ERR_POIS_UNREC = 7;
  localparam int ERR_POSTED = 8;
  localparam int ERR_LOCKED = 9;
  localparam int ERR_DROPPED = 10;
  localparam int ERR_W = 11;

  // Positions of second-domain strobes in the synchroniser bus
  localparam int SLOW_POIS = 0;
  localparam int SLOW_NOREC = 1;
  localparam int SLOW_MCB = 2;
  localparam int SLOW_MALF = 3;
  localparam logic [SLOW_W-1:0] SLOW_IDLE = 4'hF;

  // Interrupt status fields
  localparam int INT_KIND_LSB = 8;
  localparam int INT_KIND_MSB = 9;
  localparam int INT_CNT_LSB = 16;
  localparam logic [7:0] LEGACY_VEC_MASK = 8'h03;

  // Completion header layout, most significant field first
  typedef struct packed {
    logic [6:0] lowerAddr;
    logic [11:0] byteCount;
    logic [2:0] trafficClass;
    logic [1:0] attr;
    logic [15:0] requesterId;
    logic [7:0] tag;
  } peis_cpl_hdr_t;

  // Kind of the last interrupt message sent
  typedef enum logic [1:0] {
    MSG_NONE = 2'b00,
    MSG_ASSERT = 2'b01,
    MSG_DEASSERT = 2'b11,
    MSG_MSI = 2'b10
  } peis_msg_t;

endpackage

/* design/peis_sideband.sv */
// Error reporting and interrupt request sideband of an endpoint.
// Assumes user logic on clk; poisoned, malformed, multicast-blocked and
// no-recovery strobes come from the second user clock and are resynced.
//
// Functional notes
// - Locked qualifier makes queued completion a locked one
// - Malformed strobe, resynced, sets malformed error
// - Multicast-blocked strobe, resynced, sets its error
// - No-recovery marks poisoned or timeout unrecoverable
// - Poisoned strobe arrives resynced from second clock
// - Poisoned strobe acted on only when attribute set
// - Posted qualifier suppresses completion for that error
// - Completion header fields keep the fixed layout
// - Unsupported request strobe lives on main clock
// - Unsupported request ignored while buffer not ready
// - Select picks legacy assert or deassert message
// - MSI vector uses only enabled low bits
// - Legacy data picks INTA through INTD wire
// - Data output carries low MSI message data byte
// - Ready only with header room; else drop reports
// - Multiple message enable stays within 0 to 5
module peis_sideband
(
  input wire logic clk, // User clock, 40 MHz
  input wire logic nrst, // Async reset, active low
  input wire logic [peis_pkg::ADDR_W-1:0] regAddr, // Register index
  input wire logic [peis_pkg::DATA_W-1:0] regWdata, // Write data
  input wire logic regWr, // Write strobe
  input wire logic regRd, // Read strobe
  output logic [peis_pkg::DATA_W-1:0] regRdata, // Read data, cycle after strobe
  input wire logic locked_qualifier_n, // Failing request was locked
  input wire logic unsupported_request_report_n, // Unsupported request seen
  input wire logic completion_abort_report_n, // Completion aborted
  input wire logic completion_timeout_report_n, // Completion timed out
  input wire logic posted_qualifier_n, // Failing request was posted
  input wire logic [peis_pkg::HDR_W-1:0] error_completion_header, // Header
  output logic completion_header_buffer_ready_n, // Header buffer has room
  input wire logic malformed_report_n, // Malformed packet, second clock
  input wire logic multicast_blocked_report_n, // Multicast blocked, second clock
  input wire logic no_recovery_qualifier_n, // Unrecoverable, second clock
  input wire logic poisoned_report_n, // Poisoned packet, second clock
  input wire logic interrupt_request_n, // Interrupt request
  input wire logic legacy_assert_select, // 0 assert, 1 deassert
  input wire logic [7:0] interrupt_data_in, // Vector or wire select
  output logic interrupt_grant_n, // Interrupt grant
  output logic [7:0] interrupt_data_out, // Low MSI message data byte
  output logic [2:0] multi_message_enable // Enabled vector bits
);
  import peis_pkg::*;

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [SLOW_W-1:0] slowN;
  logic [ENTRY_W-1:0] bufHead;
  logic bufEmpty;
  logic bufFull;
  logic bufFullNxt;
  logic [CNT_W-1:0] bufCount;
  logic push;
  logic pop;
  logic [ENTRY_W-1:0] pushData;
  logic urAct;
  logic caAct;
  logic posted;
  logic poisAct;
  logic noRec;
  logic ctoEv;
  logic sent;
  logic [7:0] msiVec;
  logic [ERR_W-1:0] errSet;
  logic [ERR_W-1:0] errClr;
  peis_cpl_hdr_t hdrIn;

  logic poisAttr_r, poisAttr_nxt;
  logic msiEn_r, msiEn_nxt;
  logic [2:0] mme_r, mme_nxt;
  logic [7:0] msgData_r, msgData_nxt;
  logic [ERR_W-1:0] errStat_r, errStat_nxt;
  logic [1:0] ctoDly_r, ctoDly_nxt;
  logic readyN_r, readyN_nxt;
  logic grantN_r, grantN_nxt;
  logic [7:0] lastVec_r, lastVec_nxt;
  peis_msg_t lastKind_r, lastKind_nxt;
  logic [CNT16_W-1:0] sentCnt_r, sentCnt_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;

  // Low bits of message data the user may replace
  function automatic logic [7:0] vec_mask(input logic [2:0] mme);
    vec_mask = (8'h01 << mme) - 8'h01;
  endfunction

  // ************************************************************
  // Submodules
  // ************************************************************
  peis_sync u_sync (
    .clk(clk),
    .nrst(nrst),
    .din({malformed_report_n, multicast_blocked_report_n,
          no_recovery_qualifier_n, poisoned_report_n}),
    .dout(slowN)
  );

  peis_hdr_buffer u_buf (
    .clk(clk),
    .nrst(nrst),
    .push(push),
    .pushData(pushData),
    .pop(pop),
    .headData(bufHead),
    .empty(bufEmpty),
    .full(bufFull),
    .fullNxt(bufFullNxt),
    .count(bufCount)
  );

  // ************************************************************
  // Error intake
  // ************************************************************
  always_comb begin
    hdrIn = peis_cpl_hdr_t'(error_completion_header);
    urAct = !unsupported_request_report_n && !readyN_r;
    caAct = !completion_abort_report_n && !readyN_r;
    posted = !posted_qualifier_n;
    push = (urAct || caAct) && !posted;
    pushData = {!locked_qualifier_n, hdrIn};
    pop = regWr && (regAddr == REG_POP) && !bufEmpty;
    readyN_nxt = bufFullNxt;
    poisAct = !slowN[SLOW_POIS] && poisAttr_r;
    noRec = !slowN[SLOW_NOREC];
    // Timeout delayed to line up with the resynced qualifier
    ctoDly_nxt = {ctoDly_r[0], !completion_timeout_report_n};
    ctoEv = ctoDly_r[1];
    errSet = '0;
    errSet[ERR_UR] = urAct;
    errSet[ERR_CA] = caAct;
    errSet[ERR_CTO] = ctoEv;
    errSet[ERR_MALF] = !slowN[SLOW_MALF];
    errSet[ERR_MCB] = !slowN[SLOW_MCB];
    errSet[ERR_POIS] = poisAct;
    errSet[ERR_CTO_UNREC] = ctoEv && noRec;
    errSet[ERR_POIS_UNREC] = poisAct && noRec;
    errSet[ERR_POSTED] = posted && (urAct || caAct || !completion_timeout_report_n);
    errSet[ERR_LOCKED] = push && !locked_qualifier_n;
    errSet[ERR_DROPPED] = readyN_r &&
        (!unsupported_request_report_n || !completion_abort_report_n);
    errClr = (regWr && (regAddr == REG_ERR)) ? regWdata[ERR_W-1:0] : '0;
    // A new event wins over a clear in the same cycle
    errStat_nxt = (errStat_r & ~errClr) | errSet;
  end

  // ************************************************************
  // Interrupt request and grant
  // ************************************************************
  always_comb begin
    sent = !grantN_r && !interrupt_request_n;
    // Grant lasts one cycle, so a held request is granted every other cycle
    grantN_nxt = interrupt_request_n || !grantN_r;
    msiVec = (msgData_r & ~vec_mask(mme_r)) |
             (interrupt_data_in & vec_mask(mme_r));
    lastVec_nxt = lastVec_r;
    lastKind_nxt = lastKind_r;
    sentCnt_nxt = sentCnt_r;
    if (sent) begin
      sentCnt_nxt = sentCnt_r + CNT16_W'(1);
      if (msiEn_r) begin
        lastKind_nxt = MSG_MSI;
        lastVec_nxt = msiVec;
      end else begin
        lastKind_nxt = legacy_assert_select ? MSG_DEASSERT : MSG_ASSERT;
        lastVec_nxt = interrupt_data_in & LEGACY_VEC_MASK;
      end
    end
  end

  // ************************************************************
  // Register port
  // ************************************************************
  always_comb begin
    poisAttr_nxt = poisAttr_r;
    msiEn_nxt = msiEn_r;
    mme_nxt = mme_r;
    msgData_nxt = msgData_r;
    if (regWr && (regAddr == REG_CFG)) begin
      poisAttr_nxt = regWdata[CFG_POIS_BIT];
      msiEn_nxt = regWdata[CFG_MSI_BIT];
      // Out-of-range values clamp rather than wrap
      mme_nxt = (regWdata[CFG_MME_MSB:CFG_MME_LSB] > MME_MAX) ?
                MME_MAX : regWdata[CFG_MME_MSB:CFG_MME_LSB];
      msgData_nxt = regWdata[CFG_DATA_MSB:CFG_DATA_LSB];
    end
    rdata_nxt = '0;
    if (regRd) begin
      unique case (regAddr)
        REG_CFG: begin
          rdata_nxt[CFG_POIS_BIT] = poisAttr_r;
          rdata_nxt[CFG_MSI_BIT] = msiEn_r;
          rdata_nxt[CFG_MME_MSB:CFG_MME_LSB] = mme_r;
          rdata_nxt[CFG_DATA_MSB:CFG_DATA_LSB] = msgData_r;
        end
        REG_ERR: rdata_nxt[ERR_W-1:0] = errStat_r;
        REG_HDR_LO: rdata_nxt = bufHead[DATA_W-1:0];
        REG_HDR_HI: rdata_nxt[HDR_W-DATA_W+1:0] =
            {!bufEmpty, bufHead[LOCK_BIT], bufHead[HDR_W-1:DATA_W]};
        REG_INT: begin
          rdata_nxt[7:0] = lastVec_r;
          rdata_nxt[INT_KIND_MSB:INT_KIND_LSB] = lastKind_r;
          rdata_nxt[DATA_W-1:INT_CNT_LSB] = sentCnt_r;
        end
        default: rdata_nxt = '0;
      endcase
    end
  end

  // ************************************************************
  // State registers
  // ************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      poisAttr_r <= 1'b0;
      msiEn_r <= 1'b0;
      mme_r <= MME_RST;
      msgData_r <= MSG_DATA_RST;
      errStat_r <= '0;
      ctoDly_r <= '0;
      readyN_r <= 1'b0;
      grantN_r <= 1'b1;
      lastVec_r <= '0;
      lastKind_r <= MSG_NONE;
      sentCnt_r <= '0;
      rdata_r <= '0;
    end else begin
      poisAttr_r <= poisAttr_nxt;
      msiEn_r <= msiEn_nxt;
      mme_r <= mme_nxt;
      msgData_r <= msgData_nxt;
      errStat_r <= errStat_nxt;
      ctoDly_r <= ctoDly_nxt;
      readyN_r <= readyN_nxt;
      grantN_r <= grantN_nxt;
      lastVec_r <= lastVec_nxt;
      lastKind_r <= lastKind_nxt;
      sentCnt_r <= sentCnt_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign regRdata = rdata_r;
  assign completion_header_buffer_ready_n = readyN_r;
  assign interrupt_grant_n = grantN_r;
  assign interrupt_data_out = msgData_r;
  assign multi_message_enable = mme_r;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cbAssert @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_lockedEntry;
    bufEmpty && push && !locked_qualifier_n |=> !bufEmpty && bufHead[LOCK_BIT];
  endproperty
  a_lockedEntry: assert property (p_lockedEntry)
    else $error("locked completion not queued as locked");
  property p_malformed;
    !malformed_report_n |-> ##3 errStat_r[ERR_MALF];
  endproperty
  a_malformed: assert property (p_malformed)
    else $error("malformed report not recorded three cycles later");
  property p_mcBlocked;
    !multicast_blocked_report_n |-> ##3 errStat_r[ERR_MCB];
  endproperty
  a_mcBlocked: assert property (p_mcBlocked)
    else $error("multicast blocked report not recorded");
  property p_ctoUnrec;
    !completion_timeout_report_n && !no_recovery_qualifier_n |-> ##3 errStat_r[ERR_CTO_UNREC];
  endproperty
  a_ctoUnrec: assert property (p_ctoUnrec)
    else $error("unrecoverable timeout not flagged");
  property p_poisIgnored;
    (!poisAttr_r && !errStat_r[ERR_POIS]) ##1 !poisAttr_r |-> !errStat_r[ERR_POIS];
  endproperty
  a_poisIgnored: assert property (p_poisIgnored)
    else $error("poisoned report acted on while attribute clear");
  property p_postedNoCpl;
    (urAct || caAct) && posted && !pop |=> bufCount == $past(bufCount);
  endproperty
  a_postedNoCpl: assert property (p_postedNoCpl)
    else $error("posted error queued a completion");
  property p_readyRoom;
    readyN_r == (bufCount == CNT_W'(BUF_DEPTH));
  endproperty
  a_readyRoom: assert property (p_readyRoom)
    else $error("ready output disagrees with buffer room");
  property p_dropWhenBusy;
    readyN_r && !unsupported_request_report_n && !pop |=> bufCount == $past(bufCount);
  endproperty
  a_dropWhenBusy: assert property (p_dropWhenBusy)
    else $error("unsupported request taken while not ready");
  property p_legacyKind;
    sent && !msiEn_r |=> lastKind_r == ($past(legacy_assert_select) ? MSG_DEASSERT : MSG_ASSERT)
      && lastVec_r == ($past(interrupt_data_in) & LEGACY_VEC_MASK);
  endproperty
  a_legacyKind: assert property (p_legacyKind)
    else $error("legacy message kind or wire wrong");
  property p_msiVec;
    sent && msiEn_r && mme_r == MME_RST |=> lastKind_r == MSG_MSI && lastVec_r == msgData_r;
  endproperty
  a_msiVec: assert property (p_msiVec)
    else $error("single vector MSI used data input");
  property p_grantPulse;
    !interrupt_request_n && interrupt_grant_n |=> !interrupt_grant_n ##1 interrupt_grant_n;
  endproperty
  a_grantPulse: assert property (p_grantPulse)
    else $error("grant not a single cycle after request");
  property p_mmeRange;
    multi_message_enable <= MME_MAX;
  endproperty
  a_mmeRange: assert property (p_mmeRange)
    else $error("multiple message enable out of range");

  c_lockedPush: cover property (push && !locked_qualifier_n);
  c_bufFull: cover property (bufFull);
  c_poisUnrec: cover property (errStat_r[ERR_POIS_UNREC]);
  c_msiSent: cover property (sent && msiEn_r);
endmodule

/* design/peis_sync.sv */
// Two-flop synchroniser bank for strobes from the second user clock.
// Assumes the inputs idle high, as they are active-low strobes.
module peis_sync
  import peis_pkg::*;
(
  input wire logic clk, // User clock
  input wire logic nrst, // Async reset, active low
  input wire logic [SLOW_W-1:0] din, // Asynchronous strobes
  output logic [SLOW_W-1:0] dout // Synchronised strobes
);
  logic [SLOW_W-1:0] meta_r;
  logic [SLOW_W-1:0] meta_nxt;
  logic [SLOW_W-1:0] sync_r;
  logic [SLOW_W-1:0] sync_nxt;

  // ************************************************************
  // Two stages per bit; stage one feeds only stage two
  // ************************************************************
  always_comb begin
    meta_nxt = din;
    sync_nxt = meta_r;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= SLOW_IDLE;
      sync_r <= SLOW_IDLE;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign dout = sync_r;
endmodule

/* test/peis_sideband_bench.sv */
// Self-checking bench for the error and interrupt sideband.
// Assumes the user model is compiled before this file.
module peis_sideband_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import peis_pkg::*;

  // ************************************************************
  // Stimulus and wiring
  // ************************************************************
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdata;
  logic [8:0] errN = 9'h1FF;
  logic [47:0] hdr = {7'h55, 12'hABC, 3'h5, 2'h2, 16'h1234, 8'h9A};
  logic go = 1'b0;
  logic msi = 1'b0;
  logic sel = 1'b0;
  logic [7:0] vec = 8'h00;
  logic readyN, grantN, reqN, selOut, done;
  logic [7:0] dataOut, dataIn;
  logic [2:0] mme;
  int n_fail = 0;
  int compares = 0;
  logic [8:0] lm [7] = '{9'h100, 9'h180, 9'h020, 9'h040, 9'h084, 9'h011, 9'h00A};
  logic [10:0] ex [7] = '{11'h0, 11'h0A0, 11'h008, 11'h010, 11'h044, 11'h201, 11'h102};

  always #12.5 clk = ~clk;

  peis_sideband u_dut (
    .clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .locked_qualifier_n(errN[4]),
    .unsupported_request_report_n(errN[0]), .completion_abort_report_n(errN[1]),
    .completion_timeout_report_n(errN[2]), .posted_qualifier_n(errN[3]),
    .error_completion_header(hdr), .completion_header_buffer_ready_n(readyN),
    .malformed_report_n(errN[5]), .multicast_blocked_report_n(errN[6]),
    .no_recovery_qualifier_n(errN[7]), .poisoned_report_n(errN[8]),
    .interrupt_request_n(reqN), .legacy_assert_select(selOut),
    .interrupt_data_in(dataIn), .interrupt_grant_n(grantN),
    .interrupt_data_out(dataOut), .multi_message_enable(mme));

  peis_user_model u_user (
    .clk(clk), .nrst(nrst), .go(go), .msi(msi), .sel(sel), .vec(vec), .grantN(grantN),
    .dataOut(dataOut), .mme(mme), .reqN(reqN), .selOut(selOut), .dataIn(dataIn),
    .done(done));

  // ************************************************************
  // Access tasks, all entered just after a rising edge
  // ************************************************************
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
                    input string s);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 chk(s, e, regRdata & m);
    @(posedge clk);
  endtask

  task automatic err(input logic [8:0] low, input int n);
    errN <= ~low;
    repeat (n) @(posedge clk);
    errN <= 9'h1FF;
    repeat (6) @(posedge clk);
  endtask

  task automatic irq(input logic m, input logic s, input logic [7:0] v);
    msi <= m;
    sel <= s;
    vec <= v;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      #1;
      if (done) break;
    end
    chk("irq sent", 32'h1, {31'h0, done});
    @(posedge clk);
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    #(25ns * 4000);
    n_fail++;
    print_verdict();
  end

  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(REG_CFG, 32'hFFFFFFFF, 32'h0, "cfg reset");
    chk("ready reset", 32'h0, {31'h0, readyN});
    chk("grant reset", 32'h1, {31'h0, grantN});
    $display("test reset done");
    for (int i = 0; i < 7; i++) begin
      wr(REG_CFG, (i == 0) ? 32'h0 : 32'h1);
      err(lm[i], 1);
      rd(REG_ERR, 32'h7FF, {21'h0, ex[i]}, "err");
      wr(REG_ERR, 32'h7FF);
    end
    rd(REG_HDR_LO, 32'hFFFFFFFF, hdr[31:0], "hdr lo");
    rd(REG_HDR_HI, 32'hFFFFFFFF, {14'h0, 2'b11, hdr[47:32]}, "hdr hi");
    wr(REG_POP, 32'h0);
    rd(REG_HDR_HI, 32'h20000, 32'h0, "posted entry");
    $display("test error reports done");
    err(9'h001, 6);
    chk("ready full", 32'h1, {31'h0, readyN});
    rd(REG_ERR, 32'h401, 32'h401, "dropped ur");
    for (int i = 0; i < 4; i++) wr(REG_POP, 32'h0);
    chk("ready drained", 32'h0, {31'h0, readyN});
    $display("test buffer full done");
    wr(REG_CFG, 32'h0000A40B);
    rd(REG_CFG, 32'hFFFFFFFF, 32'h0000A40B, "cfg msi");
    chk("data out", 32'hA4, {24'h0, dataOut});
    chk("mme", 32'h2, {29'h0, mme});
    irq(1'b1, 1'b0, 8'h03);
    rd(REG_INT, 32'h3FF, 32'h2A7, "msi vec");
    wr(REG_CFG, 32'h0000A41F);
    rd(REG_CFG, 32'hFFFFFFFF, 32'h0000A417, "mme clamp");
    irq(1'b1, 1'b1, 8'hFF);
    rd(REG_INT, 32'h3FF, 32'h2BF, "msi vec 5");
    wr(REG_CFG, 32'h0000A403);
    irq(1'b1, 1'b0, 8'h5C);
    rd(REG_INT, 32'h3FF, 32'h2A4, "msi single");
    wr(REG_CFG, 32'h0);
    for (int s = 0; s < 2; s++) begin
      for (int w = 0; w < 4; w++) begin
        irq(1'b0, s[0], 8'(w));
        rd(REG_INT, 32'h3FF, {22'h0, s[0], 1'b1, 8'(w)}, "legacy");
      end
    end
    rd(REG_INT, 32'hFFFF0000, 32'h000B0000, "sent count");
    $display("test interrupts done");
    print_verdict();
  end
endmodule

/* test/peis_user_model.sv */
// User-side interrupt requester facing the sideband.
// Assumes the grant answers a held request within a few cycles.
module peis_user_model
  import peis_pkg::*;
(
  input wire logic clk, // User clock
  input wire logic nrst, // Async reset, active low
  input wire logic go, // Start one request
  input wire logic msi, // MSI mode
  input wire logic sel, // Legacy select wanted
  input wire logic [7:0] vec, // Vector or wire wanted
  input wire logic grantN, // Device grant
  input wire logic [7:0] dataOut, // Device message data
  input wire logic [2:0] mme, // Enabled vector bits
  output logic reqN, // Request to device
  output logic selOut, // Select to device
  output logic [7:0] dataIn, // Data to device
  output logic done // Message sent
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [8:0] m9;

  assign m9 = (9'h001 << mme) - 9'h001;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reqN <= 1'b1;
      selOut <= 1'b0;
      dataIn <= 8'h00;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (reqN && go) begin
        reqN <= 1'b0;
        selOut <= sel;
        dataIn <= msi ? ((dataOut & ~m9[7:0]) | (vec & m9[7:0])) : vec;
      end else if (!reqN && !grantN) begin
        reqN <= 1'b1;
        done <= 1'b1;
      end else if (reqN) begin
        // Idle lines toggle so no stale vector is mistaken for a live one
        dataIn <= ~dataIn;
        selOut <= ~selOut;
      end
    end
  end
endmodule
